//--- pkg/slms_pkg.sv
// ==========================================
// Register map and field layout
// ==========================================
package slms_pkg;
   localparam logic [7:0] ADDR_SLEEP_CONTROL    = 8'h01;
   localparam logic [7:0] ADDR_EDID_EDID_BRIDGE_CONTROL  = 8'h4F;
   localparam logic [7:0] ADDR_BRIDGE_CONFIG    = 8'h54;
   localparam logic [7:0] ADDR_LINK_MODE_CTL    = 8'h5B;
   localparam logic [7:0] ADDR_LINK_MODE_STATUS = 8'h5C;

   localparam int BIT_ID_SOURCE     = 0;  // edid_bridge_control
   localparam int BIT_AUTO_SLEEP    = 7;  // sleep_control
   localparam int BIT_AUX_AUDIO     = 1;  // bridge_configuration
   localparam int BIT_REMOTE_COPY   = 5;  // bridge_configuration
   localparam int BIT_EXT_CTRL      = 7;  // bridge_configuration
   localparam int BIT_AUTO_OFF      = 0;  // link_mode_control
   localparam int BIT_FORCE_LO      = 1;  // link_mode_control, 2 bits
   localparam int BIT_SEC_CTRL      = 3;  // link_mode_control
   localparam int BIT_CABLE_TYPE    = 7;  // link_mode_control

   localparam int STRAP_MSB = 2;
   localparam int STRAP_MID = 1;
   localparam int STRAP_LSB = 0;

   localparam logic [7:0] RESET_REG = 8'h00;

   // Forced mode codes in link_mode_control
   localparam logic [1:0] FORCE_SINGLE  = 2'h0;
   localparam logic [1:0] FORCE_FSINGLE = 2'h1;
   localparam logic [1:0] FORCE_DUAL    = 2'h2;
   localparam logic [1:0] FORCE_REPL    = 2'h3;

   // Pixel clock limits in MHz
   localparam logic [7:0] SINGLE_MAX_NEW_MHZ = 8'h60;  // 96
   localparam logic [7:0] SINGLE_MAX_OLD_MHZ = 8'h55;  // 85
   localparam logic [7:0] REPL_MAX_MHZ       = 8'h55;  // 85
   localparam logic [7:0] DUAL_MAX_MHZ       = 8'hAA;  // 170

   localparam int PIX_WIDTH  = 24;
   localparam int FIFO_DEPTH = 4;

   typedef enum logic [4:0] {
      SLMS_SINGLE  = 5'b0_0001,
      SLMS_FSINGLE = 5'b0_0010,
      SLMS_DUAL    = 5'b0_0100,
      SLMS_REPL    = 5'b0_1000,
      SLMS_SECONLY = 5'b1_0000
   } slms_mode_t;
endpackage

//--- core/slms_top.sv
`timescale 1ns/1ns

// ==========================================
// Pixel FIFO
// ==========================================
module slms_fifo #(
   parameter int WIDTH = slms_pkg::PIX_WIDTH,
   parameter int DEPTH = slms_pkg::FIFO_DEPTH
) (
   input  wire logic             clk,      // Core clock
   input  wire logic             rst,      // Async reset
   input  wire logic [WIDTH-1:0] in_data,  // Write data
   input  wire logic             in_valid, // Write request
   output logic                  in_ready, // Not full
   output logic      [WIDTH-1:0] out_data, // Head word
   output logic                  out_valid,// Not empty
   input  wire logic             out_ready // Pop
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ==========================================
// Strap latch and link mode select
// ==========================================
module slms_top #(
   parameter logic [7:0] DUAL_MIN_MHZ = 8'h60  // Dual auto-select threshold
) (
   input  wire logic        MCLK,             // Core clock
   input  wire logic        RST,              // Async reset
   input  wire logic [2:0]  FIRST_STRAP,      // first_config_strap code
   input  wire logic [2:0]  SECOND_STRAP,     // second_config_strap code
   input  wire logic [7:0]  REG_ADDR,         // Register address
   input  wire logic [7:0]  REG_WDATA,        // Register write data
   input  wire logic        REG_WE,           // Register write strobe
   input  wire logic        REG_RE,           // Register read strobe
   output logic      [7:0]  REG_RDATA,        // Read data, next cycle
   input  wire logic        RX0_PRESENT,      // Receiver on primary link
   input  wire logic        RX1_PRESENT,      // Receiver on secondary link
   input  wire logic        RX0_DUAL_CAP,     // Primary receiver dual capable
   input  wire logic        RX0_NEW_GEN,      // Primary receiver new generation
   input  wire logic        RX0_SEC_CTRL_CAP, // Receiver takes control on link 1
   input  wire logic [7:0]  PIX_FREQ_MHZ,     // Measured pixel clock
   input  wire logic        REMOTE_ID_AVAIL,  // Remote display ID present
   output logic             REMOTE_ID_COPY,   // Copy request pulse
   output logic             ID_SOURCE_EXT,    // display_id_source_select
   output logic             AUTO_SLEEP,       // Auto sleep enable
   output logic             AUX_AUDIO,        // Aux audio enable
   output logic             EXT_CTRL,         // external_controller_override
   output logic             CABLE_CABLE_TYPE_SELECT,       // cable_type_select
   output logic             TX0_EN,           // Primary PHY enable
   output logic             TX1_EN,           // Secondary PHY enable
   output logic             BC1_EN,           // Secondary back channel enable
   output logic             SEC_CTRL_EN,      // Control traffic on link 1
   output logic             FREQ_OVER,        // Clock above mode limit, at or above it in old single
   input  wire logic [23:0] PIX_DATA,         // Incoming pixel
   input  wire logic        PIX_VALID,        // Pixel valid
   output logic             PIX_READY,        // FIFO accepts pixel
   output logic      [23:0] TX0_DATA,         // Primary link pixel
   output logic             TX0_VALID,        // Primary link valid
   input  wire logic        TX0_READY,        // Primary link ready
   output logic      [23:0] TX1_DATA,         // Secondary link pixel
   output logic             TX1_VALID,        // Secondary link valid
   input  wire logic        TX1_READY         // Secondary link ready
);
   import slms_pkg::*;

   logic [7:0]  sleep_control;
   logic [7:0]  edid_bridge_control;
   logic [7:0]  bridge_configuration;
   logic [7:0]  link_mode_control;
   logic        strap_done;
   logic        first_cap;
   slms_mode_t  mode;
   slms_mode_t  next_mode;
   logic        copy_done;
   logic [23:0] f_data;
   logic        f_valid;
   logic        f_pop;
   logic        pix_sel;
   logic        need0;
   logic        need1;
   logic        free0;
   logic        free1;

   // ==========================================
   // Power-up strap capture
   // ==========================================
   assign first_cap = !strap_done;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         strap_done <= 1'b0;
      end else begin
         strap_done <= 1'b1;
      end
   end

   // Strap codes are already level minus one, so bits map directly
   // digitised codes
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         sleep_control <= RESET_REG;
      end else if (first_cap) begin
         sleep_control[BIT_AUTO_SLEEP] <= FIRST_STRAP[STRAP_MID];
      end else if (REG_WE && REG_ADDR == ADDR_SLEEP_CONTROL) begin
         sleep_control <= REG_WDATA;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         edid_bridge_control <= RESET_REG;
      end else if (first_cap) begin
         edid_bridge_control[BIT_ID_SOURCE] <= FIRST_STRAP[STRAP_MSB];
      end else if (REG_WE && REG_ADDR == ADDR_EDID_EDID_BRIDGE_CONTROL) begin
         edid_bridge_control <= REG_WDATA;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         bridge_configuration <= RESET_REG;
      end else if (first_cap) begin
         bridge_configuration[BIT_AUX_AUDIO]   <= FIRST_STRAP[STRAP_LSB];
         bridge_configuration[BIT_EXT_CTRL]    <= SECOND_STRAP[STRAP_MSB];
         bridge_configuration[BIT_REMOTE_COPY] <= SECOND_STRAP[STRAP_LSB];
      end else if (REG_WE && REG_ADDR == ADDR_BRIDGE_CONFIG) begin
         bridge_configuration <= REG_WDATA;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         link_mode_control <= RESET_REG;
      end else if (first_cap) begin
         link_mode_control[BIT_CABLE_TYPE] <= SECOND_STRAP[STRAP_MID];
      end else if (REG_WE && REG_ADDR == ADDR_LINK_MODE_CTL) begin
         link_mode_control <= REG_WDATA;
      end
   end

   // ==========================================
   // Register readback
   // ==========================================
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RE) begin
         unique case (REG_ADDR)
            ADDR_SLEEP_CONTROL:    REG_RDATA <= sleep_control;
            ADDR_EDID_EDID_BRIDGE_CONTROL:  REG_RDATA <= edid_bridge_control;
            ADDR_BRIDGE_CONFIG:    REG_RDATA <= bridge_configuration;
            ADDR_LINK_MODE_CTL:    REG_RDATA <= link_mode_control;
            ADDR_LINK_MODE_STATUS: REG_RDATA <= {FREQ_OVER, SEC_CTRL_EN, BC1_EN,
                                                 TX1_EN, TX0_EN, 1'b0,
                                                 mode == SLMS_SECONLY, 1'b0};
            default:               REG_RDATA <= 8'h00;
         endcase
      end
   end

   // ==========================================
   // Configuration outputs
   // ==========================================
   // cable selection
   assign CABLE_CABLE_TYPE_SELECT    = link_mode_control[BIT_CABLE_TYPE];
   assign ID_SOURCE_EXT = edid_bridge_control[BIT_ID_SOURCE];
   assign AUTO_SLEEP    = sleep_control[BIT_AUTO_SLEEP];
   assign AUX_AUDIO     = bridge_configuration[BIT_AUX_AUDIO];
   assign EXT_CTRL      = bridge_configuration[BIT_EXT_CTRL];

   // One request per availability; clearing the bit cancels
   // remote copy
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         REMOTE_ID_COPY <= 1'b0;
         copy_done      <= 1'b0;
      end else begin
         REMOTE_ID_COPY <= bridge_configuration[BIT_REMOTE_COPY] && REMOTE_ID_AVAIL
                           && !copy_done && strap_done;
         if (!REMOTE_ID_AVAIL || !bridge_configuration[BIT_REMOTE_COPY]) begin
            copy_done <= 1'b0;
         end else if (strap_done) begin
            copy_done <= 1'b1;
         end
      end
   end

   // ==========================================
   // Link mode resolution
   // ==========================================
   always_comb begin
      next_mode = SLMS_SINGLE;
      if (link_mode_control[BIT_AUTO_OFF]) begin
         unique case (link_mode_control[BIT_FORCE_LO +: 2])
            FORCE_FSINGLE: next_mode = SLMS_FSINGLE;
            FORCE_DUAL:    next_mode = SLMS_DUAL;
            FORCE_REPL:    next_mode = SLMS_REPL;
            default:       next_mode = SLMS_SINGLE;
         endcase
      end else if (RX0_PRESENT && RX0_DUAL_CAP && PIX_FREQ_MHZ >= DUAL_MIN_MHZ) begin
         next_mode = SLMS_DUAL;
      end else if (RX0_PRESENT && RX1_PRESENT) begin
         next_mode = SLMS_REPL;
      end else if (!RX0_PRESENT && RX1_PRESENT) begin
         next_mode = SLMS_SECONLY;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         mode <= SLMS_SINGLE;
      end else begin
         mode <= next_mode;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         TX0_EN      <= 1'b0;
         TX1_EN      <= 1'b0;
         BC1_EN      <= 1'b0;
         SEC_CTRL_EN <= 1'b0;
      end else begin
         TX0_EN      <= mode != SLMS_SECONLY;
         SEC_CTRL_EN <= (mode == SLMS_SINGLE || mode == SLMS_DUAL)
                        && RX0_SEC_CTRL_CAP && link_mode_control[BIT_SEC_CTRL];
         TX1_EN      <= (mode == SLMS_DUAL || mode == SLMS_REPL || mode == SLMS_SECONLY
                        || (mode == SLMS_SINGLE && RX0_SEC_CTRL_CAP
                            && link_mode_control[BIT_SEC_CTRL]));
         BC1_EN      <= mode != SLMS_FSINGLE && mode != SLMS_SECONLY
                        ? (mode != SLMS_SINGLE || RX0_SEC_CTRL_CAP) : mode == SLMS_SECONLY;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         FREQ_OVER <= 1'b0;
      end else begin
         unique case (mode)
            SLMS_DUAL: FREQ_OVER <= PIX_FREQ_MHZ > DUAL_MAX_MHZ;
            SLMS_REPL: FREQ_OVER <= PIX_FREQ_MHZ > REPL_MAX_MHZ;
            default:   FREQ_OVER <= RX0_NEW_GEN ? PIX_FREQ_MHZ > SINGLE_MAX_NEW_MHZ
                                                : PIX_FREQ_MHZ >= SINGLE_MAX_OLD_MHZ;
         endcase
      end
   end

   // ==========================================
   // Pixel path
   // ==========================================
   slms_fifo #(.WIDTH(PIX_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk      (MCLK),
      .rst      (RST),
      .in_data  (PIX_DATA),
      .in_valid (PIX_VALID),
      .in_ready (PIX_READY),
      .out_data (f_data),
      .out_valid(f_valid),
      .out_ready(f_pop)
   );

   // Replicate waits for both links, so the slower one paces the stream
   assign need0 = (mode == SLMS_SINGLE || mode == SLMS_FSINGLE || mode == SLMS_REPL)
                  || (mode == SLMS_DUAL && !pix_sel);
   assign need1 = mode == SLMS_SECONLY || mode == SLMS_REPL || (mode == SLMS_DUAL && pix_sel);
   assign free0 = !TX0_VALID || TX0_READY;
   assign free1 = !TX1_VALID || TX1_READY;
   assign f_pop = f_valid && (need0 || need1) && (!need0 || free0) && (!need1 || free1);

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         pix_sel <= 1'b0;
      end else if (mode != SLMS_DUAL) begin
         pix_sel <= 1'b0;
      end else if (f_pop) begin
         pix_sel <= !pix_sel;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         TX0_VALID <= 1'b0;
         TX0_DATA  <= 24'h00_0000;
      end else if (f_pop && need0) begin
         TX0_VALID <= 1'b1;
         TX0_DATA  <= f_data;
      end else if (TX0_READY) begin
         TX0_VALID <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         TX1_VALID <= 1'b0;
         TX1_DATA  <= 24'h00_0000;
      end else if (f_pop && need1) begin
         TX1_VALID <= 1'b1;
         TX1_DATA  <= f_data;
      end else if (TX1_READY) begin
         TX1_VALID <= 1'b0;
      end
   end

   // ==========================================
   // Checks
   // ==========================================
   sequence s_cap;
      !strap_done;
   endsequence

   sequence s_forced_stable;
      link_mode_control[BIT_AUTO_OFF] [*2];
   endsequence

   AST_ID_SOURCE_LATCH: assert property (@(posedge MCLK) disable iff (RST)
      s_cap |=> ID_SOURCE_EXT == $past(FIRST_STRAP[STRAP_MSB]))
      else $error("ID source strap not latched");

   AST_SLEEP_LATCH: assert property (@(posedge MCLK) disable iff (RST)
      s_cap |=> AUTO_SLEEP == $past(FIRST_STRAP[STRAP_MID]))
      else $error("Sleep strap not latched");

   AST_SECOND_LATCH: assert property (@(posedge MCLK) disable iff (RST)
      s_cap |=> EXT_CTRL == $past(SECOND_STRAP[STRAP_MSB])
                && CABLE_CABLE_TYPE_SELECT == $past(SECOND_STRAP[STRAP_MID])
                && bridge_configuration[BIT_REMOTE_COPY] == $past(SECOND_STRAP[STRAP_LSB]))
      else $error("Second strap not latched");

   AST_STRAP_ONCE: assert property (@(posedge MCLK) disable iff (RST)
      strap_done && !(REG_WE && REG_ADDR == ADDR_BRIDGE_CONFIG)
      |=> $stable(AUX_AUDIO))
      else $error("Strap resampled after power-up");

   AST_COPY_GATED: assert property (@(posedge MCLK) disable iff (RST)
      REMOTE_ID_COPY |-> $past(bridge_configuration[BIT_REMOTE_COPY] && REMOTE_ID_AVAIL))
      else $error("Copy without enable or source");

   AST_FSINGLE_OFF: assert property (@(posedge MCLK) disable iff (RST)
      mode == SLMS_FSINGLE |=> !TX1_EN && !BC1_EN)
      else $error("Secondary active in forced single");

   AST_FORCED_MODE: assert property (@(posedge MCLK) disable iff (RST)
      s_forced_stable ##0 (link_mode_control[BIT_FORCE_LO +: 2] == FORCE_REPL)
      |=> mode == SLMS_REPL)
      else $error("Forced mode not applied");

   AST_REPL_DETECT: assert property (@(posedge MCLK) disable iff (RST)
      !link_mode_control[BIT_AUTO_OFF] && RX0_PRESENT && RX1_PRESENT && !RX0_DUAL_CAP
      |=> mode == SLMS_REPL)
      else $error("Replicate not detected");

   AST_DUAL_ALT: assert property (@(posedge MCLK) disable iff (RST)
      mode == SLMS_DUAL && $past(mode) == SLMS_DUAL && f_pop
      |=> pix_sel != $past(pix_sel))
      else $error("Dual pixels not alternating");

   AST_REPL_SAME: assert property (@(posedge MCLK) disable iff (RST)
      f_pop && mode == SLMS_REPL |=> TX0_VALID && TX1_VALID && TX0_DATA == TX1_DATA)
      else $error("Replicate data differs");
endmodule

//--- bench/slms_rx_model.sv
`timescale 1ns/1ns
// ==========================================
// Downstream receiver pair
// ==========================================
module slms_rx_model (
   input  wire logic        clk,   // Core clock
   input  wire logic        stall, // Hold both links busy
   input  wire logic [23:0] d0,    // Primary pixel
   input  wire logic        v0,    // Primary valid
   output logic             r0,    // Primary ready
   input  wire logic [23:0] d1,    // Secondary pixel
   input  wire logic        v1,    // Secondary valid
   output logic             r1     // Secondary ready
);
   logic [23:0] q0[$];
   logic [23:0] q1[$];
   initial begin
      r0 = 1'b0;
      r1 = 1'b0;
   end
   // Ready moves just after the edge, like a real link
   always @(posedge clk) begin
      if (v0 && r0) q0.push_back(d0);
      if (v1 && r1) q1.push_back(d1);
      r0 <= #1 !stall;
      r1 <= #1 !stall;
   end
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ns
module testbench;
   import slms_pkg::*;
   logic        mclk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, avail = 1'b0;
   logic        stall = 1'b0, pv = 1'b0, ngen = 1'b1, a;
   logic [3:0]  rx = 4'h0;
   logic [2:0]  s0 = 3'h5, s1 = 3'h6;
   logic [7:0]  addr = 8'h00, wd = 8'h00, freq = 8'h32, rdata;
   logic [23:0] pd = 24'h00_0000, d0, d1, px;
   logic        cp, o_id, o_as, o_aa, o_ec, o_cc, t0e, t1e, bce, sce, fo;
   logic        prdy, v0, v1, r0, r1;
   logic [23:0] e0[$], e1[$];
   int          bad_count = 0, n_checks = 0, cyc = 0, n;
   logic [7:0]  cc[8] = '{8'h83, 8'h85, 8'h87, 8'h80, 8'h80, 8'h80, 8'h88, 8'h80};
   logic [7:0]  cf[8] = '{8'h78, 8'h96, 8'h50, 8'h32, 8'h78, 8'h32, 8'h32, 8'h32};
   logic [7:0]  cs[8] = '{8'h88, 8'h38, 8'h38, 8'h38, 8'h38, 8'h32, 8'h78, 8'h08};
   logic [3:0]  cr[8] = '{4'hE, 4'hC, 4'hC, 4'hC, 4'hE, 4'h4, 4'h9, 4'hA};
   logic [1:0]  ct[8] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1, 2'h0, 2'h0};
   logic [7:0]  fc[8] = '{8'h85, 8'h85, 8'h87, 8'h87, 8'h81, 8'h81, 8'h81, 8'h81};
   logic [7:0]  ff[8] = '{8'hAB, 8'hAA, 8'h56, 8'h55, 8'h61, 8'h60, 8'h55, 8'h54};
   logic [7:0]  fe[8] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};

   slms_top u_dut (.MCLK(mclk), .RST(rst), .FIRST_STRAP(s0), .SECOND_STRAP(s1),
      .REG_ADDR(addr), .REG_WDATA(wd), .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata),
      .RX0_PRESENT(rx[3]), .RX1_PRESENT(rx[2]), .RX0_DUAL_CAP(rx[1]), .RX0_NEW_GEN(ngen),
      .RX0_SEC_CTRL_CAP(rx[0]), .PIX_FREQ_MHZ(freq), .REMOTE_ID_AVAIL(avail),
      .REMOTE_ID_COPY(cp), .ID_SOURCE_EXT(o_id), .AUTO_SLEEP(o_as), .AUX_AUDIO(o_aa),
      .EXT_CTRL(o_ec), .CABLE_CABLE_TYPE_SELECT(o_cc), .TX0_EN(t0e), .TX1_EN(t1e), .BC1_EN(bce),
      .SEC_CTRL_EN(sce), .FREQ_OVER(fo), .PIX_DATA(pd), .PIX_VALID(pv), .PIX_READY(prdy),
      .TX0_DATA(d0), .TX0_VALID(v0), .TX0_READY(r0), .TX1_DATA(d1), .TX1_VALID(v1),
      .TX1_READY(r1));
   slms_rx_model u_rx (.clk(mclk), .stall(stall), .d0(d0), .v0(v0), .r0(r0), .d1(d1),
      .v1(v1), .r1(r1));

   always #5 mclk = ~mclk;
   // Whole run needs well under this
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      if (bad_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge mclk) #1;
   endtask
   // Strobe dropped then one idle edge, so calls never collide
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      addr = ad;
      wd = dt;
      we = 1'b1;
      tick(1);
      we = 1'b0;
      tick(1);
   endtask
   task automatic rchk(input logic [7:0] ad, input logic [7:0] e, input logic [7:0] m);
      addr = ad;
      re = 1'b1;
      tick(1);
      re = 1'b0;
      tick(1);
      chk(rdata & m, e);
   endtask
   task automatic copies(output int c);
      c = 0;
      repeat (8) begin
         tick(1);
         c += cp;
      end
   endtask
   task automatic drain();
      repeat (60) if (u_rx.q0.size() < e0.size() || u_rx.q1.size() < e1.size()) tick(1);
      tick(3);
      chk(u_rx.q0.size(), e0.size());
      chk(u_rx.q1.size(), e1.size());
      foreach (e0[k]) chk(u_rx.q0[k], e0[k]);
      foreach (e1[k]) chk(u_rx.q1[k], e1[k]);
      u_rx.q0.delete();
      u_rx.q1.delete();
   endtask

   initial begin
      tick(6);
      rst = 1'b0;
      tick(1);
      // Later strap changes must be ignored
      s0 = 3'h2;
      s1 = 3'h1;
      tick(1);
      chk({o_id, o_as, o_aa, o_ec, o_cc, cp}, 24'h2E);
      rchk(ADDR_EDID_EDID_BRIDGE_CONTROL, 8'h01, 8'hFF);
      rchk(ADDR_SLEEP_CONTROL, 8'h00, 8'hFF);
      rchk(ADDR_BRIDGE_CONFIG, 8'h82, 8'hFF);
      rchk(ADDR_LINK_MODE_CTL, 8'h80, 8'hFF);
      chk(o_cc, 1'b1);
      rchk(8'h33, 8'h00, 8'hFF);
      wr(ADDR_SLEEP_CONTROL, 8'h80);
      chk(o_as, 1'b1);
      rchk(ADDR_SLEEP_CONTROL, 8'h80, 8'hFF);
      avail = 1'b1;
      copies(n);
      chk(n, 0);
      // Drop availability so the pulse lands inside the counting window
      avail = 1'b0;
      wr(ADDR_BRIDGE_CONFIG, 8'h20);
      chk({o_ec, o_aa}, 2'h0);
      avail = 1'b1;
      copies(n);
      chk(n, 1);
      avail = 1'b0;
      for (int i = 0; i < 8; i++) begin
         rx = cr[i];
         freq = cf[i];
         wr(ADDR_LINK_MODE_CTL, cc[i]);
         tick(4);
         rchk(ADDR_LINK_MODE_STATUS, cs[i], 8'hFF);
         chk({fo, sce, bce, t1e, t0e}, cs[i][7:3]);
         e0 = {};
         e1 = {};
         for (int k = 0; k < 4; k++) begin
            px = {i[7:0], 8'h00, k[7:0]};
            if (ct[i] == 0 || ct[i] == 3 || (ct[i] == 2 && !k[0])) e0.push_back(px);
            if (ct[i] == 1 || ct[i] == 3 || (ct[i] == 2 && k[0])) e1.push_back(px);
            pd = px;
            pv = 1'b1;
            while (!prdy) tick(1);
            tick(1);
         end
         pv = 1'b0;
         drain();
      end
      for (int i = 0; i < 8; i++) begin
         freq = ff[i];
         ngen = (i < 6);
         wr(ADDR_LINK_MODE_CTL, fc[i]);
         tick(4);
         chk(fo, fe[i]);
      end
      freq = 8'h32;
      stall = 1'b1;
      tick(3);
      n = 0;
      pv = 1'b1;
      e0 = {};
      e1 = {};
      repeat (10) begin
         pd = 24'hA0_0000 + n;
         a = prdy;
         if (a) e0.push_back(pd);
         tick(1);
         n += a;
      end
      pv = 1'b0;
      chk({prdy, 8'(n)}, 9'h005);
      stall = 1'b0;
      drain();
      wrap_up();
   end
endmodule
